// *** verilog/pixel_corr_pkg.sv ***
// Constants for the pixel offset, gain and line skip stage
package pixel_corr_pkg;
    localparam int ADDR_W = 8;
    localparam int PIX_W = 14;
    localparam int COEF_W = 16;
    localparam int FIFO_W = 14;
    localparam int FIFO_D = 32;
    localparam logic [7:0] OFF_FIXED_OFFSET_HIGH = 8'h3e;
    localparam logic [7:0] OFF_FIXED_OFFSET_LOW = 8'h3f;
    localparam logic [7:0] OFF_FIXED_GAIN_HIGH = 8'h40;
    localparam logic [7:0] OFF_FIXED_GAIN_LOW = 8'h41;
    localparam logic [7:0] OFF_CORRECTION_SOURCE_CONTROL = 8'h42;
    localparam logic [7:0] OFF_LINES_SAVED_COMPLEMENT = 8'h43;
    localparam logic [7:0] OFF_LINE_GROUP_LENGTH = 8'h44;
    localparam logic [7:0] OFF_LINE_STATUS = 8'h45;
    localparam int CTRL_MULT_ENABLE_BIT = 1;
    localparam int CTRL_GAIN_SRC_BIT = 2;
    localparam int CTRL_OFFSET_SRC_BIT = 4;
    localparam logic [1:0] OFFSET_LOW_MASK = 2'h0;
    localparam int GAIN_FRAC_BITS = 14;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] RESET_GAIN_HIGH = 8'h40;
    localparam logic [8:0] LINES_PER_GROUP_BASE = 9'h100;
    localparam logic [PIX_W-1:0] PIX_MAX = 14'h3fff;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {ST_IDLE, ST_ACK} bus_state_t;
endpackage

// *** verilog/pixel_fifo.sv ***
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
`default_nettype none
module pixel_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;
    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != '0);
    assign out_data_o = mem[rd_ptr_reg];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/pixel_offset_gain_line_skip.sv ***
// Pixel offset and gain correction with n out of m line skipping
// What this block does
// - A 16-bit fixed offset is held in a high and a low byte and used when fixed offset is chosen.
// - The two low bits of the fixed offset low byte always count as zero.
// - A 16-bit fixed gain is held in a high and a low byte and used when fixed gain is chosen.
// - The gain applied is the chosen coefficient divided by 16384.
// - A control bit bypasses the multiplier so pixels pass unscaled.
// - A control bit picks the gain from the fixed registers or from per-pixel DRAM data.
// - A control bit picks the offset from the fixed registers or from per-pixel DRAM data.
// - With line skipping on, only n lines of every m scanned are saved, the rest dropped.
// - The saved count is programmed as t and means 256 minus t lines.
// - A saved value t of zero bypasses skipping and keeps every line.
// - A group length m of zero bypasses skipping and keeps every line.
`timescale 1ns/1ns
`default_nettype none
module pixel_offset_gain_line_skip (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic pix_valid_i,
    output logic pix_ready_o,
    input wire logic [13:0] pix_data_i,
    input wire logic pix_line_end_i,
    input wire logic [15:0] shade_offset_i,
    input wire logic [15:0] shade_gain_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [13:0] out_data_o
);
    localparam int PW = pixel_corr_pkg::PIX_W;
    localparam int CW = pixel_corr_pkg::COEF_W;
    localparam int FB = pixel_corr_pkg::GAIN_FRAC_BITS;

    logic [7:0] offset_high_reg;
    logic [7:0] offset_low_reg;
    logic [7:0] gain_high_reg;
    logic [7:0] gain_low_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] saved_t_reg;
    logic [7:0] group_m_reg;
    logic [7:0] line_index_reg;
    logic [31:0] readdata_reg;
    logic waitrequest_reg;
    pixel_corr_pkg::bus_state_t bus_state_reg;
    logic stage_valid_reg;
    logic [PW-1:0] stage_data_reg;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [PW-1:0] fifo_out_data;
    logic out_valid_reg;
    logic [PW-1:0] out_data_reg;
    logic pop_fifo;

    function automatic logic [31:0] read_mux(input logic [7:0] addr,
            input logic [7:0] oh, input logic [7:0] ol, input logic [7:0] gh,
            input logic [7:0] gl, input logic [7:0] c, input logic [7:0] t,
            input logic [7:0] m, input logic [7:0] li);
        logic [31:0] r;
        r = pixel_corr_pkg::READ_ZERO;
        case (addr)
            pixel_corr_pkg::OFF_FIXED_OFFSET_HIGH: r[7:0] = oh;
            pixel_corr_pkg::OFF_FIXED_OFFSET_LOW: r[7:0] = ol;
            pixel_corr_pkg::OFF_FIXED_GAIN_HIGH: r[7:0] = gh;
            pixel_corr_pkg::OFF_FIXED_GAIN_LOW: r[7:0] = gl;
            pixel_corr_pkg::OFF_CORRECTION_SOURCE_CONTROL: r[7:0] = c;
            pixel_corr_pkg::OFF_LINES_SAVED_COMPLEMENT: r[7:0] = t;
            pixel_corr_pkg::OFF_LINE_GROUP_LENGTH: r[7:0] = m;
            pixel_corr_pkg::OFF_LINE_STATUS: r[7:0] = li;
            default: r = pixel_corr_pkg::READ_ZERO;
        endcase
        return r;
    endfunction

    // Bus slave: one wait cycle, then acknowledge
    logic access;
    logic wr_now;
    assign access = avs_read_i || avs_write_i;
    assign wr_now = avs_write_i && (bus_state_reg == pixel_corr_pkg::ST_ACK)
        && avs_byteenable_i[0];

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            bus_state_reg <= pixel_corr_pkg::ST_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg <= pixel_corr_pkg::READ_ZERO;
        end else begin
            case (bus_state_reg)
                pixel_corr_pkg::ST_IDLE: begin
                    waitrequest_reg <= 1'b1;
                    if (access) begin
                        bus_state_reg <= pixel_corr_pkg::ST_ACK;
                        waitrequest_reg <= 1'b0;
                        readdata_reg <= read_mux(avs_address_i, offset_high_reg,
                            offset_low_reg, gain_high_reg, gain_low_reg, ctrl_reg,
                            saved_t_reg, group_m_reg, line_index_reg);
                    end
                end
                pixel_corr_pkg::ST_ACK: begin
                    bus_state_reg <= pixel_corr_pkg::ST_IDLE;
                    waitrequest_reg <= 1'b1;
                end
                default: begin
                    bus_state_reg <= pixel_corr_pkg::ST_IDLE;
                    waitrequest_reg <= 1'b1;
                end
            endcase
        end
    end
    assign avs_waitrequest_o = waitrequest_reg;
    assign avs_readdata_o = readdata_reg;

    // Register writes
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            offset_high_reg <= pixel_corr_pkg::RESET_BYTE;
            offset_low_reg <= pixel_corr_pkg::RESET_BYTE;
            gain_high_reg <= pixel_corr_pkg::RESET_GAIN_HIGH;
            gain_low_reg <= pixel_corr_pkg::RESET_BYTE;
            ctrl_reg <= pixel_corr_pkg::RESET_BYTE;
            saved_t_reg <= pixel_corr_pkg::RESET_BYTE;
            group_m_reg <= pixel_corr_pkg::RESET_BYTE;
        end else if (wr_now) begin
            case (avs_address_i)
                pixel_corr_pkg::OFF_FIXED_OFFSET_HIGH: offset_high_reg <= avs_writedata_i[7:0];
                pixel_corr_pkg::OFF_FIXED_OFFSET_LOW:
                    offset_low_reg <= {avs_writedata_i[7:2], pixel_corr_pkg::OFFSET_LOW_MASK};
                pixel_corr_pkg::OFF_FIXED_GAIN_HIGH: gain_high_reg <= avs_writedata_i[7:0];
                pixel_corr_pkg::OFF_FIXED_GAIN_LOW: gain_low_reg <= avs_writedata_i[7:0];
                pixel_corr_pkg::OFF_CORRECTION_SOURCE_CONTROL: ctrl_reg <= avs_writedata_i[7:0];
                pixel_corr_pkg::OFF_LINES_SAVED_COMPLEMENT: saved_t_reg <= avs_writedata_i[7:0];
                pixel_corr_pkg::OFF_LINE_GROUP_LENGTH: group_m_reg <= avs_writedata_i[7:0];
                default: ;
            endcase
        end
    end

    // Line skipping decision
    logic skip_bypass;
    logic [8:0] lines_saved;
    logic keep_line;
    assign skip_bypass = (saved_t_reg == pixel_corr_pkg::RESET_BYTE)
        || (group_m_reg == pixel_corr_pkg::RESET_BYTE);
    assign lines_saved = pixel_corr_pkg::LINES_PER_GROUP_BASE - {1'b0, saved_t_reg};
    assign keep_line = skip_bypass || ({1'b0, line_index_reg} < lines_saved);

    logic take_pix;
    assign take_pix = pix_valid_i && pix_ready_o;
    assign pix_ready_o = !stage_valid_reg || fifo_in_ready;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            line_index_reg <= pixel_corr_pkg::RESET_BYTE;
        end else if (skip_bypass) begin
            line_index_reg <= pixel_corr_pkg::RESET_BYTE;
        end else if (take_pix && pix_line_end_i) begin
            if (line_index_reg >= group_m_reg - 8'h01) begin
                line_index_reg <= pixel_corr_pkg::RESET_BYTE;
            end else begin
                line_index_reg <= line_index_reg + 8'h01;
            end
        end
    end

    // Offset and gain datapath
    logic [CW-1:0] offset_sel;
    logic [CW-1:0] gain_sel;
    logic [CW:0] diff;
    logic [PW-1:0] after_offset;
    logic [PW+CW-1:0] product;
    logic [PW+CW-FB-1:0] scaled;
    logic [PW-1:0] corrected;
    assign offset_sel = ctrl_reg[pixel_corr_pkg::CTRL_OFFSET_SRC_BIT] ? shade_offset_i
        : {offset_high_reg, offset_low_reg};
    assign gain_sel = ctrl_reg[pixel_corr_pkg::CTRL_GAIN_SRC_BIT] ? shade_gain_i
        : {gain_high_reg, gain_low_reg};
    assign diff = {3'h0, pix_data_i} - {1'b0, offset_sel};
    assign after_offset = diff[CW] ? '0 : ((|diff[CW-1:PW]) ? pixel_corr_pkg::PIX_MAX
        : diff[PW-1:0]);
    assign product = after_offset * gain_sel;
    assign scaled = product[PW+CW-1:FB];
    assign corrected = !ctrl_reg[pixel_corr_pkg::CTRL_MULT_ENABLE_BIT] ? after_offset
        : ((|scaled[PW+CW-FB-1:PW]) ? pixel_corr_pkg::PIX_MAX : scaled[PW-1:0]);

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_valid_reg <= 1'b0;
            stage_data_reg <= '0;
        end else if (pix_ready_o) begin
            stage_valid_reg <= take_pix && keep_line;
            stage_data_reg <= corrected;
        end
    end

    pixel_fifo #(
        .WIDTH(pixel_corr_pkg::FIFO_W),
        .DEPTH(pixel_corr_pkg::FIFO_D)
    ) pixel_fifo_i (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(stage_valid_reg),
        .in_ready_o(fifo_in_ready),
        .in_data_i(stage_data_reg),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(pop_fifo),
        .out_data_o(fifo_out_data)
    );

    // Registered output stage
    assign pop_fifo = !out_valid_reg || out_ready_i;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else if (pop_fifo) begin
            out_valid_reg <= fifo_out_valid;
            out_data_reg <= fifo_out_data;
        end
    end
    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;
endmodule
`default_nettype wire

// *** verification/pixel_offset_gain_line_skip_assertions.sv ***
// Checker for the pixel correction stage ports
`timescale 1ns/1ns
`default_nettype none
module pixel_corr_checker (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [7:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic pix_valid_i,
    input wire logic pix_ready_o,
    input wire logic out_valid_o,
    input wire logic out_ready_i,
    input wire logic [13:0] out_data_o
);
    logic [7:0] sh [0:6];
    logic [15:0] inflight;
    logic ack;
    logic rd_ack;
    assign ack = !avs_waitrequest_o;
    assign rd_ack = avs_read_i && ack;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh <= '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
        end else if (avs_write_i && ack && avs_byteenable_i[0]
                     && avs_address_i inside {[8'h3e:8'h44]}) begin
            sh[3'(avs_address_i - 8'h3e)] <= avs_writedata_i[7:0];
        end
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            inflight <= 16'h0000;
        end else begin
            inflight <= inflight + 16'(pix_valid_i && pix_ready_o) - 16'(out_valid_o && out_ready_i);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence s_ack;
        ack ##1 !ack;
    endsequence
    AST_READ_ACK: assert property (avs_read_i && !ack |=> s_ack)
        else $error("read not acknowledged in one cycle");
    AST_WRITE_ACK: assert property (avs_write_i && !ack |=> s_ack)
        else $error("write not acknowledged in one cycle");
    AST_ACK_CAUSE: assert property (ack |-> avs_read_i || avs_write_i)
        else $error("acknowledge without request");
    AST_UPPER_ZERO: assert property (rd_ack |-> avs_readdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    AST_UNMAPPED: assert property (rd_ack && !(avs_address_i inside {[8'h3e:8'h45]})
        |-> avs_readdata_o == 32'h0000_0000) else $error("unmapped read not zero");
    AST_READBACK: assert property (rd_ack && avs_address_i inside {[8'h3e:8'h44]}
        |-> avs_readdata_o[7:2] == sh[3'(avs_address_i - 8'h3e)][7:2])
        else $error("register read back wrong");
    AST_GROUP_INDEX: assert property (rd_ack && avs_address_i == 8'h45
        && sh[5] != 8'h00 && sh[6] != 8'h00 |-> avs_readdata_o[7:0] < sh[6])
        else $error("line index outside group");
    AST_OUT_HOLD: assert property (out_valid_o && !out_ready_i
        |=> out_valid_o && $stable(out_data_o)) else $error("output dropped under stall");
    AST_OUT_CAUSE: assert property (out_valid_o |-> inflight != 16'h0000)
        else $error("output without input pixel");
endmodule
`default_nettype wire

// *** verification/shade_dram_model.sv ***
// Behavioural model of the shading coefficient memory
`timescale 1ns/1ns
`default_nettype none
module shade_dram_model (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic take_i,
    input wire logic valid_i,
    input wire logic line_end_i,
    output logic [15:0] shade_offset_o,
    output logic [15:0] shade_gain_o
);
    logic [7:0] col_reg;
    logic [15:0] off_w;
    logic [15:0] gain_w;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) col_reg <= 8'h00;
        else if (take_i) col_reg <= line_end_i ? 8'h00 : col_reg + 8'h01;
    end
    assign off_w = 16'h0040 + {5'h00, col_reg, 3'h0};
    assign gain_w = 16'h3000 + {col_reg, 8'h00};
    // Not valid: inverted pattern
    assign shade_offset_o = valid_i ? off_w : ~off_w;
    assign shade_gain_o = valid_i ? gain_w : ~gain_w;
endmodule
`default_nettype wire

// *** verification/pixel_offset_gain_line_skip_test.sv ***
// Self-checking bench for the pixel correction stage
`timescale 1ns/1ns
`default_nettype none
module pixel_offset_gain_line_skip_test;
    logic ref_clk_i = 0, resetn_i = 0, avs_read_i = 0, avs_write_i = 0, stall = 0;
    logic [7:0] avs_address_i = 8'h00, c = 8'h00, idx = 8'h00;
    logic [31:0] avs_writedata_i = 32'h0000_0000, avs_readdata_o;
    logic [3:0] avs_byteenable_i = 4'hf;
    logic avs_waitrequest_o, pix_ready_o, out_valid_o, out_ready_i = 0;
    logic pix_valid_i = 0, pix_line_end_i = 0;
    logic [13:0] pix_data_i = 14'h0000, out_data_o;
    logic [15:0] shade_offset_i, shade_gain_i;
    logic [7:0] r [0:6] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] modes [0:5] = '{8'h00, 8'h02, 8'h06, 8'h12, 8'h16, 8'h14};
    logic [7:0] sk_t [0:4] = '{8'hfe, 8'h00, 8'hfe, 8'h01, 8'hff};
    logic [7:0] sk_m [0:4] = '{8'h05, 8'h05, 8'h00, 8'h03, 8'h04};
    logic [31:0] rq [$];
    logic [13:0] pq [$];
    int errors = 0, checks = 0, n_ok, refused, i, j;
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) out_ready_i <= !stall && ($urandom % 4 != 0);
    pixel_offset_gain_line_skip pixel_offset_gain_line_skip_i (.ref_clk_i, .resetn_i,
        .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
        .avs_readdata_o, .avs_waitrequest_o, .pix_valid_i, .pix_ready_o, .pix_data_i,
        .pix_line_end_i, .shade_offset_i, .shade_gain_i, .out_valid_o, .out_ready_i,
        .out_data_o);
    shade_dram_model shade_dram_model_i (.ref_clk_i, .resetn_i,
        .take_i(pix_valid_i && pix_ready_o), .valid_i(pix_valid_i),
        .line_end_i(pix_line_end_i), .shade_offset_o(shade_offset_i),
        .shade_gain_o(shade_gain_i));
    task summarize;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task hang;
        errors++;
        summarize;
    endtask
    task cmp_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task cmp_pix(input logic [13:0] e, input logic [13:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("unexpected pixel exp %h got %h", e, g);
        end
    endtask
    always @(negedge ref_clk_i) begin
        if (avs_read_i && !avs_waitrequest_o)
            cmp_reg("readdata", rq.size() > 0 ? rq.pop_front() : 32'hxxxx_xxxx, avs_readdata_o);
        if (out_valid_o && out_ready_i)
            cmp_pix(pq.size() > 0 ? pq.pop_front() : 14'hxxxx, out_data_o);
    end
    task bus(input logic [7:0] a, input logic w, input logic [7:0] v, input logic [3:0] be);
        int k;
        logic [31:0] e;
        e = 32'h0000_0000;
        if (a inside {[8'h3e:8'h44]}) e[7:0] = r[3'(a - 8'h3e)];
        if (a == 8'h45) e[7:0] = idx;
        if (!w) rq.push_back(e);
        avs_address_i <= a;
        avs_read_i <= !w;
        avs_write_i <= w;
        avs_byteenable_i <= be;
        avs_writedata_i <= {24'h00_0000, v};
        k = 0;
        do begin
            @(negedge ref_clk_i);
            k++;
        end while (avs_waitrequest_o !== 1'b0 && k < 200);
        if (k >= 200) hang;
        @(posedge ref_clk_i);
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (w && be[0] && a inside {[8'h3e:8'h44]}) r[3'(a - 8'h3e)] = v;
        if (r[5] == 8'h00 || r[6] == 8'h00) idx = 8'h00;
        @(posedge ref_clk_i);
    endtask
    function automatic logic [13:0] expf(input logic [13:0] d);
        logic [15:0] o, g;
        logic [31:0] p;
        o = r[4][4] ? 16'h0040 + {5'h00, c, 3'h0} : {r[0], r[1][7:2], 2'h0};
        g = r[4][2] ? 16'h3000 + {c, 8'h00} : {r[2], r[3]};
        p = (32'(d) > 32'(o)) ? 32'(d) - 32'(o) : 32'h0000_0000;
        if (r[4][1]) p = (p * 32'(g)) >> 14;
        return (p > 32'h0000_3fff) ? 14'h3fff : p[13:0];
    endfunction
    task px(input logic [13:0] d, input logic e);
        int k;
        pix_valid_i <= 1'b1;
        pix_data_i <= d;
        pix_line_end_i <= e;
        k = 0;
        do begin
            @(negedge ref_clk_i);
            k++;
        end while (pix_ready_o !== 1'b1 && k < (stall ? 12 : 500));
        @(posedge ref_clk_i);
        if (pix_ready_o === 1'b1) begin
            if (r[5] == 0 || r[6] == 0 || idx < pixel_corr_pkg::LINES_PER_GROUP_BASE - r[5])
                pq.push_back(expf(d));
            c++;
            n_ok++;
            if (e) begin
                c = 8'h00;
                idx = (r[5] == 0 || r[6] == 0 || idx + 8'h01 >= r[6]) ? 8'h00 : idx + 8'h01;
            end
        end else if (!stall) hang;
        else refused = 1;
    endtask
    task drain;
        for (int k = 0; k < 3000 && pq.size() > 0; k++) @(posedge ref_clk_i);
        if (pq.size() > 0) hang;
    endtask
    initial begin
        void'($urandom(32'h8a8e));
        repeat (16) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        for (i = 0; i < 8; i++) bus(8'(8'h3e + i), 0, 8'h00, 4'hf);
        bus(8'h50, 1, 8'h5a, 4'hf);
        bus(8'h50, 0, 8'h00, 4'hf);
        for (i = 0; i < 7; i++) bus(8'(8'h3e + i), 1, 8'($urandom) & 8'hfc, 4'hf);
        bus(8'h40, 1, 8'h11, 4'he);
        for (i = 0; i < 7; i++) bus(8'(8'h3e + i), 0, 8'h00, 4'hf);
        bus(8'h43, 1, 8'h00, 4'hf);
        for (i = 0; i < 6; i++) begin
            bus(8'h3e, 1, 8'($urandom % 8), 4'hf);
            bus(8'h3f, 1, 8'($urandom) | 8'h03, 4'hf);
            bus(8'h40, 1, 8'($urandom % 128), 4'hf);
            bus(8'h41, 1, 8'($urandom), 4'hf);
            bus(8'h42, 1, modes[i], 4'hf);
            for (j = 0; j < 8; j++) px(14'($urandom), j == 7);
            pix_valid_i <= 1'b0;
            drain;
        end
        for (i = 0; i < 5; i++) begin
            bus(8'h43, 1, 8'h00, 4'hf);
            bus(8'h44, 1, sk_m[i], 4'hf);
            bus(8'h43, 1, sk_t[i], 4'hf);
            for (j = 0; j < (sk_m[i] == 0 ? 6 : 3 * sk_m[i]); j++) px(14'($urandom), j % 3 == 2);
            pix_valid_i <= 1'b0;
            bus(8'h45, 0, 8'h00, 4'hf);
        end
        drain;
        bus(8'h43, 1, 8'h00, 4'hf);
        stall <= 1'b1;
        n_ok = 0;
        refused = 0;
        while (refused == 0 && n_ok < 80) px(14'($urandom), 1'b0);
        pix_valid_i <= 1'b0;
        cmp_reg("fill", 32'h0000_0001, 32'(refused == 1 && n_ok >= pixel_corr_pkg::FIFO_D));
        stall <= 1'b0;
        drain;
        summarize;
    end
endmodule
bind pixel_offset_gain_line_skip pixel_corr_checker pixel_corr_checker_i (.ref_clk_i, .resetn_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i,
    .avs_readdata_o, .avs_waitrequest_o, .pix_valid_i, .pix_ready_o, .out_valid_o,
    .out_ready_i, .out_data_o);
`default_nettype wire
